// ---- ir_pwm_top.sv ----
/*
 * infrared carrier and pwm generator with two reloading 8-bit counters
 * that can be joined into one 16-bit timer, plus four underflow flags.
 * assumes an ahb-lite master with single word transfers and a single clock.
 */
`timescale 1ns/1ps
// Summary of operation
// (R1) carrier period is preset plus one ticks of counter two's clock
// (R2) high interval lasts high preset plus one ticks of its clock
// (R3) low interval lasts low preset plus one ticks of its clock
// (R4) gate select set: output carries the carrier during the pulse interval
// (R5) gate select clear and not low-only: plain high/low pwm waveform
// (R6) enable falling: keep sending until the next high-timer underflow
// (R7) low-only select: high timer ignored, low timer alone shapes output
// (R8) cascade off: two independent 8-bit timers, each its own flag
// (R9) cascade on: one 16-bit timer on counter one's clock and flag
// (R10) cascade on: counter two's clock, prescale and flag are ignored
// (R11) cascade: counter one low byte, two high byte, flag at zero
// (R12) written counter values are reloaded after each expiry
// (R13) software disables counters, sets cascade, writes, enables counter one
// (R14) software disables counters, clears cascade, then writes new values
// (R15) underflow flags are taken on the falling edge of the request
// (R16) a falling edge sets its status flag only when its mask bit is set
// (R17) counter one vector 000c, counter two vector 000f
// (R18) high timer vector 0012, low timer vector 0015
// (R19) idle with enable low: output pin held low
module ir_pwm_top #(
   parameter int SUB_DIV   = ir_pwm_pkg::SUB_DIV,
   parameter int INSTR_DIV = ir_pwm_pkg::INSTR_DIV
) (
   input  wire logic                hclk,
   input  wire logic                hresetn,
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic      [31:0]         hrdata,
   output logic                     hreadyout,
   output logic                     hresp,
   output logic                     ir_output_pin
);
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_HIGH,
      ST_LOW
   } phase_t;

   typedef struct packed {
      logic                wr_pend;
      logic [7:0]          wr_addr;
      logic [31:0]         rdata;
      logic                ready;
      logic [7:0]          ir_control;
      ir_pwm_pkg::clk_cfg_t c1_clk;
      ir_pwm_pkg::clk_cfg_t c2_clk;
      ir_pwm_pkg::clk_cfg_t hw_clk;
      ir_pwm_pkg::clk_cfg_t lw_clk;
      logic [7:0]          carrier_preset;
      logic [7:0]          high_width_preset;
      logic [7:0]          low_width_preset;
      logic [7:0]          counter_one_reload;
      logic [7:0]          counter_one;
      logic [7:0]          counter_two;
      logic [3:0]          int_mask;
      logic [3:0]          interrupt_flags;
      logic [3:0]          req;
      logic [3:0]          req_prev;
      logic [10:0]         sub_div;
      logic [1:0]          instr_div;
      logic                sub_tick;
      logic                instr_tick;
      phase_t              phase;
      logic                out;
   } top_state_t;

   top_state_t s_q;
   top_state_t s_d;

   logic       c1_tick;
   logic       c2_tick;
   logic       hw_tick;
   logic       lw_tick;
   logic       hw_uf;
   logic       lw_uf;
   logic       c1_uf;
   logic       c2_uf;
   logic       carrier;
   logic       ir_en;
   logic       gate_sel;
   logic       low_only;
   logic       cascade;
   logic       counter_one_en;
   logic       counter_two_en;
   function automatic logic src_pick(input ir_pwm_pkg::clk_cfg_t c,
                                     input logic instr_t,
                                     input logic sub_t);
      src_pick = c.sub_sel ? sub_t : instr_t;
   endfunction

   function automatic logic [7:0] vector_of(input logic [3:0] f);
      if (f[ir_pwm_pkg::F_COUNTER_ONE]) begin
         vector_of = ir_pwm_pkg::VEC_COUNTER_ONE;
      end else if (f[ir_pwm_pkg::F_COUNTER_TWO]) begin
         vector_of = ir_pwm_pkg::VEC_COUNTER_TWO;
      end else if (f[ir_pwm_pkg::F_HIGH]) begin
         vector_of = ir_pwm_pkg::VEC_HIGH;
      end else if (f[ir_pwm_pkg::F_LOW]) begin
         vector_of = ir_pwm_pkg::VEC_LOW;
      end else begin
         vector_of = ir_pwm_pkg::VEC_NONE;
      end
   endfunction
   assign ir_en    = s_q.ir_control[ir_pwm_pkg::B_IR_ENABLE];
   assign gate_sel = s_q.ir_control[ir_pwm_pkg::B_GATE_SEL];
   assign low_only = s_q.ir_control[ir_pwm_pkg::B_LOW_ONLY];
   assign cascade  = s_q.ir_control[ir_pwm_pkg::B_CASCADE];
   assign counter_one_en  = s_q.ir_control[ir_pwm_pkg::B_COUNTER_ONE_EN];
   assign counter_two_en  = s_q.ir_control[ir_pwm_pkg::B_COUNTER_TWO_EN];
   ir_prescaler u_pre_c1 (
      .clk      (hclk),
      .rst_n    (hresetn),
      .src_tick (src_pick(s_q.c1_clk, s_q.instr_tick, s_q.sub_tick)),
      .prescale (s_q.c1_clk.prescale),
      .tick     (c1_tick)
   );

   ir_prescaler u_pre_c2 (
      .clk      (hclk),
      .rst_n    (hresetn),
      .src_tick (src_pick(s_q.c2_clk, s_q.instr_tick, s_q.sub_tick)),
      .prescale (s_q.c2_clk.prescale),
      .tick     (c2_tick)
   );

   ir_prescaler u_pre_hw (
      .clk      (hclk),
      .rst_n    (hresetn),
      .src_tick (src_pick(s_q.hw_clk, s_q.instr_tick, s_q.sub_tick)),
      .prescale (s_q.hw_clk.prescale),
      .tick     (hw_tick)
   );

   ir_prescaler u_pre_lw (
      .clk      (hclk),
      .rst_n    (hresetn),
      .src_tick (src_pick(s_q.lw_clk, s_q.instr_tick, s_q.sub_tick)),
      .prescale (s_q.lw_clk.prescale),
      .tick     (lw_tick)
   );

   // width timers are held at their preset outside their own phase
   ir_width_timer #(.W(8)) u_high (
      .clk       (hclk),
      .rst_n     (hresetn),
      .run       (s_q.phase == ST_HIGH),
      .tick      (hw_tick),
      .preset    (s_q.high_width_preset),
      .underflow (hw_uf)
   );

   ir_width_timer #(.W(8)) u_low (
      .clk       (hclk),
      .rst_n     (hresetn),
      .run       (s_q.phase == ST_LOW),
      .tick      (lw_tick),
      .preset    (s_q.low_width_preset),
      .underflow (lw_uf)
   );

   // counter underflows; in cascade the high byte steps on low-byte wrap
   always_comb begin
      if (cascade) begin
         c1_uf = counter_one_en & c1_tick & (s_q.counter_one == 8'h00)
                 & (s_q.counter_two == 8'h00);                          // [R9] [R11]
         c2_uf = 1'b0;                                                   // [R10]
      end else begin
         c1_uf = counter_one_en & c1_tick & (s_q.counter_one == 8'h00);         // [R8]
         c2_uf = counter_two_en & c2_tick & (s_q.counter_two == 8'h00);         // [R8]
      end
   end

   // carrier high for the upper half of the count; period is preset + 1
   assign carrier = counter_two_en & !cascade
                    & (s_q.counter_two > (s_q.carrier_preset >> 1));     // [R1]

   always_comb begin
      logic        addr_ok;
      logic [7:0]  a;
      logic [31:0] rd;
      logic [3:0]  clr;
      logic [3:0]  fall;
      addr_ok = 1'b0;
      a       = 8'h00;
      rd      = 32'h0000_0000;
      clr     = 4'h0;
      fall    = 4'h0;
      s_d     = s_q;

      // time base: instruction clock and sub-oscillator enables
      s_d.instr_tick = 1'b0;
      s_d.sub_tick   = 1'b0;
      if (s_q.instr_div == 2'(INSTR_DIV - 1)) begin
         s_d.instr_div  = 2'h0;
         s_d.instr_tick = 1'b1;
      end else begin
         s_d.instr_div = s_q.instr_div + 2'h1;
      end
      if (s_q.sub_div == 11'(SUB_DIV - 1)) begin
         s_d.sub_div  = 11'h000;
         s_d.sub_tick = 1'b1;
      end else begin
         s_d.sub_div = s_q.sub_div + 11'h001;
      end

      // bus data phase: writes land here, using hwdata of this cycle
      s_d.ready = 1'b1;
      if (s_q.wr_pend) begin
         unique case (s_q.wr_addr)
            ir_pwm_pkg::OFS_IR_CONTROL:      s_d.ir_control = hwdata[7:0];
            ir_pwm_pkg::OFS_COUNTER_CONTROL: begin
               s_d.c1_clk = {hwdata[3], hwdata[2:0]};
               s_d.c2_clk = {hwdata[7], hwdata[6:4]};
            end
            ir_pwm_pkg::OFS_WIDTH_CONTROL: begin
               s_d.hw_clk = {hwdata[3], hwdata[2:0]};
               s_d.lw_clk = {hwdata[7], hwdata[6:4]};
            end
            ir_pwm_pkg::OFS_CARRIER_PRESET:  s_d.carrier_preset     = hwdata[7:0];
            ir_pwm_pkg::OFS_HIGH_PRESET:     s_d.high_width_preset  = hwdata[7:0];
            ir_pwm_pkg::OFS_LOW_PRESET:      s_d.low_width_preset   = hwdata[7:0];
            ir_pwm_pkg::OFS_COUNTER_ONE:     s_d.counter_one_reload = hwdata[7:0];
            ir_pwm_pkg::OFS_INT_MASK:        s_d.int_mask           = hwdata[3:0];
            ir_pwm_pkg::OFS_INT_FLAGS:       clr                    = hwdata[3:0];
            default: ;
         endcase
      end

      // bus address phase
      s_d.wr_pend = 1'b0;
      if (hsel && hready && htrans == ir_pwm_pkg::HTRANS_NONSEQ) begin
         a       = {haddr[7:2], 2'b00};
         addr_ok = (haddr[31:8] == 24'h000000);
         s_d.wr_pend = hwrite & addr_ok;
         s_d.wr_addr = a;
         if (!hwrite && addr_ok) begin
            unique case (a)
               ir_pwm_pkg::OFS_IR_CONTROL: begin
                  rd[7:0] = s_q.ir_control;
                  rd[ir_pwm_pkg::B_PIN_STATE] = s_q.out;
                  rd[ir_pwm_pkg::B_BUSY]      = (s_q.phase != ST_IDLE);
               end
               ir_pwm_pkg::OFS_COUNTER_CONTROL: rd[7:0] = {s_q.c2_clk, s_q.c1_clk};
               ir_pwm_pkg::OFS_WIDTH_CONTROL:   rd[7:0] = {s_q.lw_clk, s_q.hw_clk};
               ir_pwm_pkg::OFS_CARRIER_PRESET:  rd[7:0] = s_q.carrier_preset;
               ir_pwm_pkg::OFS_HIGH_PRESET:     rd[7:0] = s_q.high_width_preset;
               ir_pwm_pkg::OFS_LOW_PRESET:      rd[7:0] = s_q.low_width_preset;
               ir_pwm_pkg::OFS_COUNTER_ONE:     rd[7:0] = s_q.counter_one_reload;
               ir_pwm_pkg::OFS_INT_MASK:        rd[3:0] = s_q.int_mask;
               ir_pwm_pkg::OFS_INT_FLAGS:       rd[3:0] = s_q.interrupt_flags;
               ir_pwm_pkg::OFS_INT_VECTOR:      rd[7:0] = vector_of(s_q.interrupt_flags); // [R17] [R18]
               ir_pwm_pkg::OFS_COUNT_STATUS:    rd[15:0] = {s_q.counter_two, s_q.counter_one};
               default:                         rd = 32'h0000_0000;
            endcase
         end
         s_d.rdata = rd;
      end

      // counter one: held at its reload while disabled
      if (!counter_one_en) begin
         s_d.counter_one = s_q.counter_one_reload;
      end else if (c1_tick) begin
         if (s_q.counter_one == 8'h00 && (!cascade || s_q.counter_two == 8'h00)) begin
            s_d.counter_one = s_q.counter_one_reload;                    // [R12]
         end else begin
            s_d.counter_one = s_q.counter_one - 8'h01;                   // [R11]
         end
      end

      // counter two: own clock alone, or stepped by the low byte in cascade
      if (cascade) begin
         if (!counter_one_en) begin
            s_d.counter_two = s_q.carrier_preset;
         end else if (c1_tick && s_q.counter_one == 8'h00) begin
            if (s_q.counter_two == 8'h00) begin
               s_d.counter_two = s_q.carrier_preset;                     // [R12] [R11]
            end else begin
               s_d.counter_two = s_q.counter_two - 8'h01;                // [R9]
            end
         end
      end else if (!counter_two_en) begin
         s_d.counter_two = s_q.carrier_preset;
      end else if (c2_tick) begin
         if (s_q.counter_two == 8'h00) begin
            s_d.counter_two = s_q.carrier_preset;                        // [R1] [R12]
         end else begin
            s_d.counter_two = s_q.counter_two - 8'h01;
         end
      end

      // output sequencer
      unique case (s_q.phase)
         ST_IDLE: begin
            if (ir_en) begin
               s_d.phase = low_only ? ST_LOW : ST_HIGH;                  // [R7]
            end
         end
         ST_HIGH: begin
            if (low_only) begin
               s_d.phase = ST_LOW;                                       // [R7]
            end else if (hw_uf) begin
               s_d.phase = ir_en ? ST_LOW : ST_IDLE;                     // [R2] [R6]
            end
         end
         ST_LOW: begin
            if (lw_uf) begin
               if (low_only) begin
                  s_d.phase = ir_en ? ST_LOW : ST_IDLE;                  // [R3] [R7]
               end else begin
                  s_d.phase = ST_HIGH;                                   // [R3] [R6]
               end
            end
         end
         default: s_d.phase = ST_IDLE;
      endcase

      unique case (s_d.phase)
         ST_HIGH: s_d.out = gate_sel ? carrier : 1'b1;                   // [R4] [R5]
         ST_LOW:  s_d.out = low_only ? (gate_sel ? carrier : 1'b1) : 1'b0; // [R5] [R7]
         default: s_d.out = 1'b0;                                        // [R19]
      endcase

      // request lines idle high and dip for one cycle on each underflow
      s_d.req[ir_pwm_pkg::F_COUNTER_ONE] = ~c1_uf;
      s_d.req[ir_pwm_pkg::F_COUNTER_TWO] = ~c2_uf;
      s_d.req[ir_pwm_pkg::F_HIGH] = ~hw_uf;
      s_d.req[ir_pwm_pkg::F_LOW]  = ~lw_uf;
      s_d.req_prev = s_q.req;
      fall = s_q.req_prev & ~s_q.req;                                    // [R15]

      // write-one-to-clear; a new edge in the same cycle wins over the clear
      s_d.interrupt_flags = (s_q.interrupt_flags & ~clr) | (fall & s_q.int_mask); // [R16]
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q                    <= '0;
         s_q.req                <= 4'hf;
         s_q.req_prev           <= 4'hf;
         s_q.ir_control         <= ir_pwm_pkg::CTRL_RESET;
         s_q.carrier_preset     <= ir_pwm_pkg::PRESET_RESET;
         s_q.high_width_preset  <= ir_pwm_pkg::PRESET_RESET;
         s_q.low_width_preset   <= ir_pwm_pkg::PRESET_RESET;
         s_q.counter_one_reload <= ir_pwm_pkg::PRESET_RESET;
         s_q.int_mask           <= ir_pwm_pkg::MASK_RESET;
         s_q.phase              <= ST_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign hrdata        = s_q.rdata;
   assign hreadyout     = s_q.ready;
   assign hresp         = 1'b0;
   assign ir_output_pin = s_q.out;

endmodule

// ---- ir_pwm_pkg.sv ----
/*
 * package for the infrared carrier / pwm generator: register map, field
 * positions, reset values, interrupt vectors, clock ratios and timer types.
 * assumes a 50 MHz bus clock and a 32.768 kHz sub-oscillator rate.
 */
package ir_pwm_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_IR_CONTROL      = 8'h00;
   localparam logic [7:0] OFS_COUNTER_CONTROL = 8'h04;
   localparam logic [7:0] OFS_WIDTH_CONTROL   = 8'h08;
   localparam logic [7:0] OFS_CARRIER_PRESET  = 8'h0c;
   localparam logic [7:0] OFS_HIGH_PRESET     = 8'h10;
   localparam logic [7:0] OFS_LOW_PRESET      = 8'h14;
   localparam logic [7:0] OFS_COUNTER_ONE     = 8'h18;
   localparam logic [7:0] OFS_INT_MASK        = 8'h1c;
   localparam logic [7:0] OFS_INT_FLAGS       = 8'h20;
   localparam logic [7:0] OFS_INT_VECTOR      = 8'h24;
   localparam logic [7:0] OFS_COUNT_STATUS    = 8'h28;

   // ir_control bit positions
   localparam int B_IR_ENABLE  = 0;
   localparam int B_GATE_SEL   = 1;
   localparam int B_LOW_ONLY   = 2;
   localparam int B_CASCADE    = 3;
   localparam int B_COUNTER_ONE_EN    = 4;
   localparam int B_COUNTER_TWO_EN    = 5;
   localparam int B_PIN_STATE  = 8;
   localparam int B_BUSY       = 9;

   // interrupt flag / mask bit positions
   localparam int F_COUNTER_ONE = 0;
   localparam int F_COUNTER_TWO = 1;
   localparam int F_HIGH = 2;
   localparam int F_LOW  = 3;

   localparam logic [7:0] CTRL_RESET  = 8'h00;
   localparam logic [7:0] PRESET_RESET = 8'h00;
   localparam logic [3:0] MASK_RESET  = 4'h0;

   // service vectors
   localparam logic [7:0] VEC_NONE = 8'h00;
   localparam logic [7:0] VEC_COUNTER_ONE = 8'h0c;
   localparam logic [7:0] VEC_COUNTER_TWO = 8'h0f;
   localparam logic [7:0] VEC_HIGH = 8'h12;
   localparam logic [7:0] VEC_LOW  = 8'h15;

   // clock rates
   localparam int CLK_HZ       = 50_000_000;
   localparam int SUB_FREQ_HZ  = 32768;
   localparam int SUB_DIV      = CLK_HZ / SUB_FREQ_HZ;
   localparam int INSTR_DIV    = 2;

   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

   // one timer clock choice: source and prescale exponent
   typedef struct packed {
      logic       sub_sel;
      logic [2:0] prescale;
   } clk_cfg_t;

   typedef struct packed {
      logic run;
      logic tick;
      logic underflow;
   } timer_evt_t;

endpackage

// ---- ir_prescaler.sv ----
/*
 * prescaler: passes one source tick out of every 2**prescale ticks.
 * assumes src_tick is a one-cycle enable pulse on clk.
 */
`timescale 1ns/1ps
module ir_prescaler (
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                src_tick,
   input  wire logic [2:0]          prescale,
   output logic                     tick
);
   typedef struct packed {
      logic [6:0] cnt;
   } pre_state_t;

   pre_state_t s_q;
   pre_state_t s_d;

   function automatic logic [6:0] low_mask(input logic [2:0] p);
      low_mask = 7'((8'h01 << p) - 8'h01);
   endfunction

   always_comb begin
      s_d = s_q;
      if (src_tick) begin
         s_d.cnt = s_q.cnt + 7'h01;
      end
   end

   assign tick = src_tick & ((s_q.cnt & low_mask(prescale)) == low_mask(prescale));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// ---- ir_width_timer.sv ----
/*
 * reloading down timer for one pulse interval: held at its preset while
 * idle, counts preset..0 on ticks while run, flags underflow at zero.
 * assumes tick is a one-cycle enable pulse on clk.
 */
`timescale 1ns/1ps
module ir_width_timer #(
   parameter int W = 8
) (
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                run,
   input  wire logic                tick,
   input  wire logic [W-1:0]        preset,
   output logic                     underflow
);
   typedef struct packed {
      logic [W-1:0] cnt;
   } wt_state_t;

   wt_state_t s_q;
   wt_state_t s_d;

   assign underflow = run & tick & (s_q.cnt == '0);

   always_comb begin
      s_d = s_q;
      if (!run || underflow) begin
         s_d.cnt = preset;
      end else if (tick) begin
         s_d.cnt = s_q.cnt - W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// ---- ir_pwm_props.sv ----
/* checker for the ir pwm block, watching only its top ports.
   assumes single word transfers and the short presets the bench uses. */
`timescale 1ns/1ps
module ir_pwm_props (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        ir_output_pin
);
   logic       ap_q;
   logic       wr_q;
   logic [7:0] a_q;
   logic [7:0] ctl_q;
   logic [7:0] hp_q;
   logic [7:0] wc_q;
   logic [3:0] msk_q;
   logic [7:0] hi_q;
   logic [7:0] off_q;
   wire        dw    = ap_q & wr_q;
   wire        rdp   = ap_q & ~wr_q;
   wire        plain = ~ctl_q[1] & ~ctl_q[2] & (wc_q[3:0] == 4'h0);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_q  <= 1'b0;
         wr_q  <= 1'b0;
         a_q   <= 8'h00;
         ctl_q <= 8'h00;
         hp_q  <= 8'h00;
         wc_q  <= 8'h00;
         msk_q <= 4'h0;
         hi_q  <= 8'h00;
         off_q <= 8'h00;
      end else begin
         if (hready) begin
            ap_q <= hsel & (htrans == 2'b10);
            wr_q <= hwrite;
            a_q  <= haddr[7:0];
         end
         if (dw && a_q == 8'h00) ctl_q <= hwdata[7:0];
         if (dw && a_q == 8'h08) wc_q <= hwdata[7:0];
         if (dw && a_q == 8'h10) hp_q <= hwdata[7:0];
         if (dw && a_q == 8'h1c) msk_q <= hwdata[3:0];
         hi_q <= ir_output_pin ? hi_q + 8'h01 : 8'h00;
         // saturates so the idle check fires once per disable
         if (ctl_q[0]) off_q <= 8'h00;
         else if (off_q != 8'hff) off_q <= off_q + 8'h01;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_enable;
      $rose(ctl_q[0]) && plain;
   endsequence
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("hresp not okay");
   a_ready_up: assert property ($past(hresetn) |-> hreadyout)
      else $error("hreadyout low after reset");
   a_reset_quiet: assert property (@(posedge hclk) disable iff (1'b0)
      !hresetn |-> !ir_output_pin && !hreadyout)
      else $error("outputs active in reset");
   a_vec_legal: assert property (rdp && a_q == 8'h24 |->
      hrdata inside {32'h0, 32'hc, 32'hf, 32'h12, 32'h15})
      else $error("illegal vector value");
   a_flag_masked: assert property (rdp && a_q == 8'h20 |->
      (hrdata[3:0] & ~msk_q) == 4'h0 && hrdata[31:4] == 28'h0)
      else $error("flag set while masked out");
   a_high_width: assert property ($fell(ir_output_pin) && ctl_q[0] && plain |->
      hi_q + 8'h01 >= 8'd2 * (hp_q + 8'h01) && hi_q <= 8'd2 * (hp_q + 8'h01) + 8'd2)
      else $error("high pulse width wrong");
   a_pin_starts: assert property (s_enable |-> ##[1:8] ir_output_pin)
      else $error("pwm did not start");
   a_stop_low: assert property (off_q == 8'd60 |-> !ir_output_pin)
      else $error("pin still driven after disable");
endmodule
bind ir_pwm_top ir_pwm_props i_ir_pwm_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ir_output_pin(ir_output_pin));

// ---- ir_load_model.sv ----
/* emitter load on the infrared pin: counts rises, last high run and
   rise-to-rise period. assumes the pin is a level registered on hclk. */
`timescale 1ns/1ps
module ir_load_model (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ir_output_pin,
   output logic      [15:0] rises,
   output logic      [15:0] hi_len,
   output logic      [15:0] per
);
   logic        pin_q;
   logic [15:0] run_q;
   logic [15:0] since_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_q   <= 1'b0;
         run_q   <= 16'h0;
         since_q <= 16'h0;
         rises   <= 16'h0;
         hi_len  <= 16'h0;
         per     <= 16'h0;
      end else begin
         pin_q <= ir_output_pin;
         run_q <= (ir_output_pin == pin_q) ? run_q + 16'h1 : 16'h1;
         since_q <= since_q + 16'h1;
         if (!ir_output_pin && pin_q) hi_len <= run_q;
         if (ir_output_pin && !pin_q) begin
            rises   <= rises + 16'h1;
            per     <= since_q + 16'h1;
            since_q <= 16'h0;
         end
      end
   end
endmodule

// ---- tb_top.sv ----
/* self-checking bench for the ir pwm block over ahb-lite.
   assumes the load model on the pin and a short sub-oscillator divider. */
`timescale 1ns/1ps
module tb_top;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic        hwrite;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        hready;
   logic        hresp;
   logic        ir_output_pin;
   logic [15:0] rises;
   logic [15:0] hi_len;
   logic [15:0] per;
   logic [31:0] q;
   logic [15:0] r0;
   int          err_total;
   int          checks_done;
   ir_pwm_top #(.SUB_DIV(4), .INSTR_DIV(2)) i_ir_pwm_top (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
      .hresp(hresp), .ir_output_pin(ir_output_pin));
   ir_load_model i_ir_load_model (.hclk(hclk), .hresetn(hresetn),
      .ir_output_pin(ir_output_pin), .rises(rises), .hi_len(hi_len), .per(per));
   always #10 hclk = ~hclk;
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      htrans <= 2'b10;
      hwrite <= w;
      haddr  <= {24'h0, a};
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(n, q, e);
   endtask
   function automatic logic inr(input logic [15:0] v, input int lo, input int hi);
      return v >= lo && v <= hi;
   endfunction
   task automatic wrise(input int n);
      r0 = rises;
      for (int i = 0; i < 400 && rises < r0 + n; i++) @(posedge hclk);
   endtask
   task automatic stop_idle;
      wr(8'h00, 32'h0);
      repeat (70) @(posedge hclk);
      rc("idle", 8'h00, 32'h0);
   endtask
   task automatic final_report;
      if (err_total == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #200000;
      err_total++;
      final_report;
   end
   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      hsel <= 1'b1;
      @(posedge hclk);
      rc("ctrl", 8'h00, 32'h0);
      rc("vec", 8'h24, ir_pwm_pkg::VEC_NONE);
      wr(8'h2c, 32'h5a);
      rc("unmapped", 8'h2c, 32'h0);
      // plain pwm: high 8 ticks, low 3 ticks of the instruction clock
      wr(8'h1c, 32'hb);
      wr(8'h10, 32'h7);
      wr(8'h14, 32'h2);
      wr(8'h00, 32'h1);
      wrise(3);
      chk("hi_len", inr(hi_len, 16, 17), 1'b1);
      chk("period", inr(per, 22, 24), 1'b1);
      rc("flags", 8'h20, 32'h8);
      rc("vec_low", 8'h24, ir_pwm_pkg::VEC_LOW);
      wrise(1);
      wr(8'h00, 32'h0);
      repeat (3) @(posedge hclk);
      chk("tail", ir_output_pin, 1'b1);
      stop_idle;
      // carrier of 4 ticks gated into the high phase
      wr(8'h0c, 32'h3);
      wr(8'h00, 32'h23);
      wrise(2);
      chk("carrier", per, 32'h8);
      stop_idle;
      r0 = rises;
      wr(8'h00, 32'h5);
      repeat (60) @(posedge hclk);
      chk("low_only", rises - r0, 32'h1);
      stop_idle;
      wr(8'h18, 32'h3);
      wr(8'h0c, 32'h5);
      wr(8'h20, 32'hf);
      wr(8'h00, 32'h30);
      repeat (40) @(posedge hclk);
      rc("two_flags", 8'h20, 32'h3);
      rc("vec_c1", 8'h24, ir_pwm_pkg::VEC_COUNTER_ONE);
      wr(8'h20, 32'hf);
      repeat (30) @(posedge hclk);
      rc("reload", 8'h20, 32'h3);
      // 16-bit 0x0102, counter two prescale must not matter
      wr(8'h00, 32'h0);
      wr(8'h00, 32'h8);
      wr(8'h18, 32'h2);
      wr(8'h0c, 32'h1);
      wr(8'h04, 32'h70);
      wr(8'h20, 32'hf);
      wr(8'h00, 32'h18);
      repeat (400) @(posedge hclk);
      rc("casc_early", 8'h20, 32'h0);
      repeat (200) @(posedge hclk);
      rc("casc_done", 8'h20, 32'h1);
      wr(8'h00, 32'h0);
      wr(8'h04, 32'h0);
      wr(8'h18, 32'h3);
      wr(8'h0c, 32'h1);
      wr(8'h20, 32'hf);
      wr(8'h00, 32'h20);
      repeat (40) @(posedge hclk);
      rc("c2_alone", 8'h20, 32'h2);
      rc("vec_c2", 8'h24, ir_pwm_pkg::VEC_COUNTER_TWO);
      final_report;
   end
endmodule
